/* hdl/ihsar_defines.vh */
// Constants of the high-speed mode and alert-response serial slave.
`ifndef IHSAR_DEFINES_VH
`define IHSAR_DEFINES_VH

// ==========================================================================
// Clock and timing
// ==========================================================================
`define IHSAR_CLK_NS          50
`define IHSAR_TIMEOUT_MS      28
`define IHSAR_TIMEOUT_CYC     ((`IHSAR_TIMEOUT_MS * 1000000) / `IHSAR_CLK_NS)
`define IHSAR_TIMEOUT_W       20
`define IHSAR_FS_SPIKE_NS     100
`define IHSAR_HS_SPIKE_NS     50
`define IHSAR_FS_FILT_CYC     (`IHSAR_FS_SPIKE_NS / `IHSAR_CLK_NS)
`define IHSAR_HS_FILT_CYC     (`IHSAR_HS_SPIKE_NS / `IHSAR_CLK_NS)

// ==========================================================================
// Bus codes
// ==========================================================================
`define IHSAR_HS_CODE         5'h01
`define IHSAR_ARA_ADDR        7'h0C
`define IHSAR_BASE_ADDR       5'h10
`define IHSAR_ARA_LSB         1'b0

// ==========================================================================
// Reset values
// ==========================================================================
`define IHSAR_PIN_RST         4'h3

`endif

/* hdl/ihsar_slave.v */
// Serial bus slave with high-speed mode entry and alert-response answer.
// How it works
// - The code byte is not acknowledged but switches the filters to HS.
// - After a repeated start the normal protocol runs at up to 3.4 MHz.
// - A stop leaves HS mode and restores the standard/fast filtering.
// - The alert-response address is accepted as a read target too.
// - With an alert pending the slave acks and sends its own address.
// - Several answering slaves arbitrate bit by bit on the data line.
// - A loser does not ack and keeps its alert line low until cleared or until it wins a later answer.
// - The slave address is 10000xx, chosen by the select pin per start.
// - A 28 ms timeout releases a stalled transaction.
// - Every byte, the alert answer included, goes MSB first.
`timescale 1ns/1ps
`include "ihsar_defines.vh"

module ihsar_slave #(
   parameter [`IHSAR_TIMEOUT_W-1:0] TIMEOUT_CYC = `IHSAR_TIMEOUT_CYC
) (
   input  wire       ref_clk_i,   // 20 MHz system clock
   input  wire       rst_i,       // synchronous reset, active high
   input  wire       scl_i,       // bus clock line level
   input  wire       sda_i,       // bus data line level
   input  wire [1:0] addr_sel_i,  // select pin level code (GND,VS,SDA,SCL)
   input  wire       alert_set_i, // pulse: alert condition raised
   input  wire       alert_clr_i, // pulse: alert condition cleared
   input  wire [7:0] tx_data_i,   // byte to send on a read
   output wire       sda_o,       // data line drive value, always low
   output wire       sda_oe_o,    // high while pulling the data line low
   output wire       alert_n_o,   // alert line, low while alert pending
   output wire       hs_mode_o,   // high-speed filtering active
   output wire [7:0] rx_data_o,   // last byte written by the master
   output wire       rx_valid_o,  // pulse: rx_data_o updated
   output wire       tx_load_o    // pulse: tx_data_i taken
);

   // =======================================================================
   // States
   // =======================================================================
   localparam [7:0] ST_IDLE = 8'h01;
   localparam [7:0] ST_ADDR = 8'h02;
   localparam [7:0] ST_ACKA = 8'h04;
   localparam [7:0] ST_RX   = 8'h08;
   localparam [7:0] ST_ACKR = 8'h10;
   localparam [7:0] ST_TX   = 8'h20;
   localparam [7:0] ST_ACKT = 8'h40;
   localparam [7:0] ST_WAIT = 8'h80;
   // Filter counts are worked out as integers and cut to the counter width.
   localparam integer FS_INT = `IHSAR_FS_FILT_CYC;
   localparam integer HS_INT = `IHSAR_HS_FILT_CYC;
   localparam [1:0] FS_LIM  = FS_INT[1:0];
   localparam [1:0] HS_LIM  = HS_INT[1:0];
   localparam [3:0] RST_PIN = `IHSAR_PIN_RST;

   reg                       hs_reg;
   reg  [7:0]                st_reg;
   reg  [7:0]                sh_reg;
   reg  [3:0]                cnt_reg;
   reg                       rd_reg;
   reg                       ara_reg;
   reg                       nack_reg;
   reg                       oe_reg;
   reg                       pend_reg;
   reg                       alert_n_reg;
   reg  [6:0]                own_reg;
   reg  [7:0]                rx_reg;
   reg                       rxv_reg;
   reg                       txl_reg;
   reg                       scl_d_reg;
   reg                       sda_d_reg;
   reg  [`IHSAR_TIMEOUT_W-1:0] to_reg;
   wire [3:0]                pin_filt;
   wire [1:0]                lim = hs_reg ? HS_LIM : FS_LIM;

   // =======================================================================
   // Pin synchronisers and spike filters
   // =======================================================================
   // Three flops per pin; a new level is taken once the second and third
   // agree and stay against the filtered value for the spike window.
   wire [3:0] pin_raw = {addr_sel_i, sda_i, scl_i};
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_pin
         reg       s1_reg;
         reg       s2_reg;
         reg       s3_reg;
         reg       f_reg;
         reg [1:0] c_reg;
         always @(posedge ref_clk_i) begin
            if (rst_i) begin
               s1_reg <= RST_PIN[g];
               s2_reg <= RST_PIN[g];
               s3_reg <= RST_PIN[g];
               f_reg  <= RST_PIN[g];
               c_reg  <= 2'h0;
            end else begin
               s1_reg <= pin_raw[g];
               s2_reg <= s1_reg;
               s3_reg <= s2_reg;
               if (s2_reg != s3_reg || s3_reg == f_reg) begin
                  c_reg <= 2'h0;
               end else if (c_reg >= lim) begin
                  f_reg <= s3_reg;
                  c_reg <= 2'h0;
               end else begin
                  c_reg <= c_reg + 2'h1;
               end
            end
         end
         assign pin_filt[g] = f_reg;
      end
   endgenerate

   wire scl      = pin_filt[0];
   wire sda      = pin_filt[1];
   wire scl_rise = scl & ~scl_d_reg;
   wire scl_fall = ~scl & scl_d_reg;
   wire start    = scl & scl_d_reg & ~sda & sda_d_reg;
   wire stop     = scl & scl_d_reg & sda & ~sda_d_reg;
   wire to_hit   = (to_reg >= TIMEOUT_CYC);
   wire ara_win  = ara_reg & (st_reg == ST_TX) & scl_fall
                   & (cnt_reg == 4'h8);
   wire own_hit  = (sh_reg[7:1] == own_reg);
   wire ara_hit  = (sh_reg[7:1] == `IHSAR_ARA_ADDR) & sh_reg[0] & pend_reg;

   // =======================================================================
   // Alert state
   // =======================================================================
   // A raise in the same cycle as a clear wins, so no alert is lost.
   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         pend_reg    <= 1'b0;
         alert_n_reg <= 1'b1;
      end else begin
         pend_reg    <= alert_set_i
                        | (pend_reg & ~alert_clr_i & ~ara_win);
         alert_n_reg <= ~pend_reg;
      end
   end

   // =======================================================================
   // Bus state machine
   // =======================================================================
   always @(posedge ref_clk_i) begin
      if (rst_i) begin
         hs_reg    <= 1'b0;
         st_reg    <= ST_IDLE;
         sh_reg    <= 8'h00;
         cnt_reg   <= 4'h0;
         rd_reg    <= 1'b0;
         ara_reg   <= 1'b0;
         nack_reg  <= 1'b0;
         oe_reg    <= 1'b0;
         own_reg   <= {`IHSAR_BASE_ADDR, 2'h0};
         rx_reg    <= 8'h00;
         rxv_reg   <= 1'b0;
         txl_reg   <= 1'b0;
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
         to_reg    <= {`IHSAR_TIMEOUT_W{1'b0}};
      end else begin
         scl_d_reg <= scl;
         sda_d_reg <= sda;
         rxv_reg   <= 1'b0;
         txl_reg   <= 1'b0;
         // Only a low clock held inside a transaction counts as a stall.
         if (st_reg == ST_IDLE || scl || scl_fall) begin
            to_reg <= {`IHSAR_TIMEOUT_W{1'b0}};
         end else if (!to_hit) begin
            to_reg <= to_reg + 1'b1;
         end
         if (stop) begin
            hs_reg <= 1'b0;
            st_reg <= ST_IDLE;
            oe_reg <= 1'b0;
         end else if (start) begin
            // A repeated start keeps HS mode while it is set.
            st_reg  <= ST_ADDR;
            cnt_reg <= 4'h0;
            oe_reg  <= 1'b0;
            ara_reg <= 1'b0;
            own_reg <= {`IHSAR_BASE_ADDR, pin_filt[3:2]};
         end else if (to_hit) begin
            st_reg <= ST_IDLE;
            oe_reg <= 1'b0;
         end else begin
            case (st_reg)
               ST_ADDR: begin
                  if (scl_rise) begin
                     sh_reg  <= {sh_reg[6:0], sda};
                     cnt_reg <= cnt_reg + 4'h1;
                  end else if (scl_fall && cnt_reg == 4'h8) begin
                     rd_reg <= sh_reg[0];
                     if (sh_reg[7:3] == `IHSAR_HS_CODE) begin
                        hs_reg <= 1'b1;
                        st_reg <= ST_WAIT;
                     end else if (own_hit || ara_hit) begin
                        ara_reg <= ara_hit & ~own_hit;
                        oe_reg  <= 1'b1;
                        st_reg  <= ST_ACKA;
                     end else begin
                        st_reg <= ST_WAIT;
                     end
                  end
               end
               ST_ACKA: begin
                  if (scl_fall) begin
                     cnt_reg <= 4'h0;
                     if (rd_reg) begin
                        if (ara_reg) begin
                           sh_reg <= {own_reg, `IHSAR_ARA_LSB};
                           oe_reg <= ~own_reg[6];
                        end else begin
                           sh_reg  <= tx_data_i;
                           oe_reg  <= ~tx_data_i[7];
                           txl_reg <= 1'b1;
                        end
                        st_reg <= ST_TX;
                     end else begin
                        oe_reg <= 1'b0;
                        st_reg <= ST_RX;
                     end
                  end
               end
               ST_RX: begin
                  if (scl_rise) begin
                     sh_reg  <= {sh_reg[6:0], sda};
                     cnt_reg <= cnt_reg + 4'h1;
                  end else if (scl_fall && cnt_reg == 4'h8) begin
                     oe_reg  <= 1'b1;
                     rx_reg  <= sh_reg;
                     rxv_reg <= 1'b1;
                     st_reg  <= ST_ACKR;
                  end
               end
               ST_ACKR: begin
                  if (scl_fall) begin
                     oe_reg  <= 1'b0;
                     cnt_reg <= 4'h0;
                     st_reg  <= ST_RX;
                  end
               end
               ST_TX: begin
                  if (scl_rise) begin
                     cnt_reg <= cnt_reg + 4'h1;
                     // Released a one but the line reads zero: lost.
                     if (ara_reg && !oe_reg && !sda) begin
                        st_reg <= ST_WAIT;
                     end
                  end else if (scl_fall) begin
                     if (cnt_reg == 4'h8) begin
                        oe_reg <= 1'b0;
                        st_reg <= ST_ACKT;
                     end else begin
                        sh_reg <= {sh_reg[6:0], 1'b0};
                        oe_reg <= ~sh_reg[6];
                     end
                  end
               end
               ST_ACKT: begin
                  if (scl_rise) begin
                     nack_reg <= sda;
                  end else if (scl_fall) begin
                     cnt_reg <= 4'h0;
                     if (nack_reg || ara_reg) begin
                        st_reg <= ST_WAIT;
                     end else begin
                        sh_reg  <= tx_data_i;
                        oe_reg  <= ~tx_data_i[7];
                        txl_reg <= 1'b1;
                        st_reg  <= ST_TX;
                     end
                  end
               end
               ST_IDLE, ST_WAIT: begin
                  oe_reg <= 1'b0;
               end
               default: begin
                  st_reg <= ST_IDLE;
                  oe_reg <= 1'b0;
               end
            endcase
         end
      end
   end

   // The pull is a constant low; only the enable moves the line.
   reg sda_lvl_reg;
   always @(posedge ref_clk_i) begin
      sda_lvl_reg <= 1'b0;
   end

   assign sda_o      = sda_lvl_reg;
   assign sda_oe_o   = oe_reg;
   assign alert_n_o  = alert_n_reg;
   assign hs_mode_o  = hs_reg;
   assign rx_data_o  = rx_reg;
   assign rx_valid_o = rxv_reg;
   assign tx_load_o  = txl_reg;

endmodule

/* tb/ihsar_master_model.sv */
// Bus master model, with a rival alerting slave on the data line.
`timescale 1ns/1ps
module ihsar_master_model (
   input  wire logic sda_i,       // resolved data line
   output logic      scl_low_o,   // master pulls SCL low
   output logic      sda_low_o,   // master pulls SDA low
   output logic      rival_low_o  // rival slave pulls SDA low
);
   // Quarter bit time; 625 ns keeps the code byte at 400 kHz.
   int q = 625;
   initial begin
      scl_low_o = 1'b0;
      sda_low_o = 1'b0;
      rival_low_o = 1'b0;
   end
   task automatic bit_x(input logic b, input logic rv, output logic r);
      sda_low_o = !b;
      rival_low_o = !rv;
      #q scl_low_o = 1'b0;
      #(2*q) r = sda_i;
      scl_low_o = 1'b1;
      #q;
   endtask
   task automatic start();
      sda_low_o = 1'b0;
      rival_low_o = 1'b0;
      #q scl_low_o = 1'b0;
      #q sda_low_o = 1'b1;
      #q scl_low_o = 1'b1;
      #q;
   endtask
   task automatic stop();
      sda_low_o = 1'b1;
      #q scl_low_o = 1'b0;
      #q sda_low_o = 1'b0;
      #(2*q);
   endtask
   task automatic sendbits(input logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) bit_x(d[i], 1'b1, r);
   endtask
   task automatic wbyte(input logic [7:0] d, output logic ack);
      logic r;
      sendbits(d);
      bit_x(1'b1, 1'b1, r);
      ack = !r;
   endtask
   // The read always ends with a not-acknowledge from the master.
   task automatic rbyte(output logic [7:0] d, input logic [7:0] rv);
      logic r;
      for (int i = 7; i >= 0; i--) bit_x(1'b1, rv[i], d[i]);
      bit_x(1'b1, 1'b1, r);
   endtask
endmodule

/* tb/ihsar_slave_chk.sv */
// Assertions on the ports of the serial slave.
`timescale 1ns/1ps
module ihsar_slave_chk #(
   parameter int TIMEOUT_CYC = 200
) (
   input wire logic ref_clk_i,   // clock
   input wire logic rst_i,       // reset
   input wire logic scl_i,       // bus clock
   input wire logic sda_i,       // bus data
   input wire logic alert_set_i, // alert raise
   input wire logic alert_clr_i, // alert clear
   input wire logic sda_o,       // drive value
   input wire logic sda_oe_o,    // drive enable
   input wire logic alert_n_o,   // alert line
   input wire logic hs_mode_o,   // HS filters
   input wire logic rx_valid_o,  // byte pulse
   input wire logic tx_load_o    // load pulse
);
   int cnt;
   default clocking @(posedge ref_clk_i);
   endclocking
   default disable iff (rst_i);
   // Cycles of a held data line while SCL is low.
   always @(posedge ref_clk_i) begin
      if (rst_i || scl_i || !sda_oe_o) cnt <= 0;
      else cnt <= cnt + 1;
   end
   a_drive_only_low: assert property (sda_o == 1'b0)
      else $error("data drive value not low");
   a_drive_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
      else $error("data drive changed while SCL high");
   a_hs_no_ack: assert property (
      $rose(hs_mode_o) |-> !scl_i ##1 !sda_oe_o [*8])
      else $error("master code acknowledged");
   a_stop_hs_exit: assert property (
      scl_i && $rose(sda_i) |-> ##[1:12] !hs_mode_o)
      else $error("HS mode kept after stop");
   a_alert_raise: assert property (alert_set_i |-> ##[1:3] !alert_n_o)
      else $error("alert line not lowered");
   a_alert_clear: assert property (
      alert_clr_i && !alert_set_i |-> ##[1:3] alert_n_o)
      else $error("alert line not released on clear");
   a_rx_pulse: assert property (rx_valid_o |-> !scl_i ##1 !rx_valid_o)
      else $error("byte pulse malformed");
   a_tx_pulse: assert property ($rose(tx_load_o) |=> $fell(tx_load_o))
      else $error("load pulse longer than a cycle");
   a_timeout_bound: assert property (cnt < TIMEOUT_CYC + 16)
      else $error("stalled bus not released");
   c_hs: cover property ($rose(hs_mode_o));
   c_win: cover property ($rose(alert_n_o));
   c_rx: cover property (rx_valid_o);
endmodule
bind ihsar_slave ihsar_slave_chk #(.TIMEOUT_CYC(TIMEOUT_CYC)) chk_u (
   .ref_clk_i(ref_clk_i), .rst_i(rst_i), .scl_i(scl_i), .sda_i(sda_i),
   .alert_set_i(alert_set_i), .alert_clr_i(alert_clr_i), .sda_o(sda_o),
   .sda_oe_o(sda_oe_o), .alert_n_o(alert_n_o), .hs_mode_o(hs_mode_o),
   .rx_valid_o(rx_valid_o), .tx_load_o(tx_load_o));

/* tb/testbench.sv */
// Self-checking bench of the serial slave.
`timescale 1ns/1ps
module testbench;
   logic       ref_clk_i = 1'b0;
   logic       rst_i = 1'b1;
   logic [1:0] addr_sel_i = 2'h3;
   logic       alert_set_i = 1'b0;
   logic       alert_clr_i = 1'b0;
   logic [7:0] tx_data_i = 8'hA5;
   logic [7:0] d;
   logic       ack;
   int         n_fail = 0;
   int         samples_checked = 0;
   int         cyc = 0;
   int         n_rxv = 0;
   int         n_txl = 0;
   wire        scl_low, sda_low, rival_low, sda_o, sda_oe_o, alert_n_o;
   wire        hs_mode_o, rx_valid_o, tx_load_o;
   wire  [7:0] rx_data_o;
   // Pulled-up lines: low while any party pulls.
   wire        scl = !scl_low;
   wire        sda = !(sda_low | rival_low | sda_oe_o);
   ihsar_slave #(.TIMEOUT_CYC(20'd200)) dut_u (.ref_clk_i(ref_clk_i),
      .rst_i(rst_i), .scl_i(scl), .sda_i(sda), .addr_sel_i(addr_sel_i),
      .alert_set_i(alert_set_i), .alert_clr_i(alert_clr_i),
      .tx_data_i(tx_data_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
      .alert_n_o(alert_n_o), .hs_mode_o(hs_mode_o), .rx_data_o(rx_data_o),
      .rx_valid_o(rx_valid_o), .tx_load_o(tx_load_o));
   ihsar_master_model mm_u (.sda_i(sda), .scl_low_o(scl_low),
      .sda_low_o(sda_low), .rival_low_o(rival_low));
   initial forever #25 ref_clk_i = !ref_clk_i;
   task automatic end_of_test();
      $display("checked %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(posedge ref_clk_i) begin
      if (!rst_i && rx_valid_o === 1'b1) n_rxv <= n_rxv + 1;
      if (!rst_i && tx_load_o === 1'b1) n_txl <= n_txl + 1;
   end
   always @(posedge ref_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         n_fail++;
         end_of_test();
      end
   end
   task automatic cmp(input logic [7:0] got, exp, input string what);
      samples_checked++;
      if (got !== exp) begin
         n_fail++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   task automatic pulse(input logic clr);
      @(posedge ref_clk_i);
      alert_set_i <= !clr;
      alert_clr_i <= clr;
      @(posedge ref_clk_i);
      alert_set_i <= 1'b0;
      alert_clr_i <= 1'b0;
      repeat (4) @(negedge ref_clk_i);
   endtask
   task automatic ara(input logic [7:0] rv, input logic [7:0] exp);
      mm_u.start();
      mm_u.wbyte(8'h19, ack);
      cmp(ack, 8'h01, "alert call ack");
      mm_u.rbyte(d, rv);
      cmp(d, exp, "alert answer byte");
      mm_u.stop();
   endtask
   task automatic t_write();
      for (int s = 0; s < 4; s++) begin
         @(posedge ref_clk_i);
         addr_sel_i <= s[1:0];
         mm_u.start();
         mm_u.wbyte({5'h10, s[1:0], 1'b0}, ack);
         cmp(ack, 8'h01, "own address ack");
         mm_u.wbyte(8'hC2 + s[7:0], ack);
         cmp(rx_data_o, 8'hC2 + s[7:0], "written byte");
         mm_u.stop();
      end
      mm_u.start();
      mm_u.wbyte(8'h88, ack);
      cmp(ack, 8'h00, "foreign address nack");
      mm_u.stop();
      cmp(n_rxv[7:0], 8'h04, "byte pulses");
      $display("write test done");
   endtask
   task automatic t_hs();
      for (int k = 0; k < 2; k++) begin
         mm_u.start();
         mm_u.wbyte(k ? 8'h0F : 8'h08, ack);
         cmp(ack, 8'h00, "master code nack");
         cmp(hs_mode_o, 8'h01, "hs entered");
         mm_u.q = 250;
         mm_u.start();
         mm_u.wbyte(8'h87, ack);
         cmp(ack, 8'h01, "hs read ack");
         mm_u.rbyte(d, 8'hFF);
         cmp(d, 8'hA5, "hs read byte");
         mm_u.start();
         cmp(hs_mode_o, 8'h01, "hs kept by repeated start");
         mm_u.stop();
         mm_u.q = 625;
         cmp(hs_mode_o, 8'h00, "hs left at stop");
      end
      cmp(n_txl[7:0], 8'h02, "load pulses");
      $display("hs test done");
   endtask
   task automatic t_timeout();
      mm_u.start();
      mm_u.sendbits(8'h86);
      repeat (10) @(negedge ref_clk_i);
      cmp(sda_oe_o, 8'h01, "ack driven");
      repeat (250) @(negedge ref_clk_i);
      cmp(sda_oe_o, 8'h00, "stalled bus released");
      mm_u.stop();
      $display("timeout test done");
   endtask
   task automatic t_ara();
      mm_u.start();
      mm_u.wbyte(8'h19, ack);
      cmp(ack, 8'h00, "idle alert call nack");
      mm_u.stop();
      pulse(1'b0);
      cmp(alert_n_o, 8'h00, "alert line low");
      ara(8'hFF, 8'h86);
      cmp(alert_n_o, 8'h01, "winner frees alert");
      pulse(1'b0);
      pulse(1'b1);
      cmp(alert_n_o, 8'h01, "cleared alert");
      $display("alert test done");
   endtask
   task automatic t_arb();
      @(posedge ref_clk_i);
      addr_sel_i <= 2'h2;
      pulse(1'b0);
      ara(8'h82, 8'h82);
      cmp(alert_n_o, 8'h00, "loser keeps alert");
      ara(8'hFF, 8'h84);
      cmp(alert_n_o, 8'h01, "late winner frees alert");
      $display("arbitration test done");
   endtask
   initial begin
      repeat (2) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      repeat (12) @(negedge ref_clk_i);
      cmp({alert_n_o, hs_mode_o, sda_oe_o}, 8'h04, "idle outputs");
      t_write();
      t_hs();
      t_timeout();
      t_ara();
      t_arb();
      end_of_test();
   end
endmodule
